/* File: shared/cgocr_pkg.sv */
// constants for the clock generator output configuration bank
package cgocr_pkg;

    typedef logic [7:0] cgocr_byte_t;
    typedef logic [9:0] cgocr_mv_t;

    // ==========================================================
    // register map
    localparam int REG_COUNT = 6;
    localparam logic [2:0] IDX_REF = 3'h0;
    localparam logic [2:0] IDX_RSVD = 3'h1;
    localparam logic [2:0] IDX_DIFF = 3'h2;
    localparam logic [2:0] IDX_IDENT = 3'h3;
    localparam logic [2:0] IDX_COUNT = 3'h4;
    localparam logic [2:0] IDX_SWING = 3'h5;
    localparam logic [2:0] IDX_LAST = 3'h5;

    // ==========================================================
    // field positions
    localparam int REF_EN_BIT = 2;
    localparam int CLKA_EN_BIT = 7;
    localparam int CLKB_EN_BIT = 6;
    localparam int SWING_SEL_BIT = 7;
    localparam int SWING_CODE_HI = 6;
    localparam int SWING_CODE_LO = 4;
    localparam int CMD_BYTE_MODE_BIT = 7;

    // ==========================================================
    // reset values; both identity nibbles are arbitrary
    localparam logic [3:0] REV_CODE = 4'h1;
    localparam logic [3:0] MAKER_IDENT = 4'h5;
    localparam cgocr_byte_t RST_REF = 8'h04;
    localparam cgocr_byte_t RST_RSVD = 8'h00;
    localparam cgocr_byte_t RST_DIFF = 8'hc0;
    localparam cgocr_byte_t RST_IDENT = {REV_CODE, MAKER_IDENT};
    localparam cgocr_byte_t RST_COUNT = 8'h06;
    localparam cgocr_byte_t RST_SWING = 8'hd8;
    localparam logic [5:0][7:0] REG_RESET = {RST_SWING, RST_COUNT, RST_IDENT, RST_DIFF, RST_RSVD, RST_REF};

    // ==========================================================
    // serial target, swing and rate tables
    localparam cgocr_byte_t TARGET_ADDR = 8'hd6;
    localparam cgocr_mv_t SWING_BASE_MV = 10'h12c;
    localparam cgocr_mv_t SWING_STEP_MV = 10'h064;
    localparam cgocr_mv_t SWING_DEFAULT_MV = 10'h2bc;
    localparam cgocr_byte_t RATE_100_MHZ = 8'h64;
    localparam cgocr_byte_t RATE_125_MHZ = 8'h7d;
    localparam cgocr_byte_t RATE_200_MHZ = 8'hc8;
    localparam logic [1:0] SS_100_FLAT = 2'h0;
    localparam logic [1:0] SS_100_SPREAD = 2'h1;
    localparam logic [1:0] SS_125_FLAT = 2'h2;
    localparam logic [1:0] SS_200_FLAT = 2'h3;

    // ==========================================================
    // pin synchroniser lanes and output lanes
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_REF = 2;
    localparam int SY_CLKA = 3;
    localparam int SY_CLKB = 4;
    localparam int SY_SSL = 5;
    localparam int SY_SSH = 6;
    localparam int SY_LANES = 7;
    localparam logic [1:0] SYNC_FILL = 2'h3;
    localparam int NUM_OUTS = 3;
    localparam int OUT_REF = 0;
    localparam int OUT_CLKA = 1;
    localparam int OUT_CLKB = 2;

endpackage

/* File: shared/cgocr_gate_if.sv */
// link between the bank and one glitch-free output gate
`timescale 1ns/1ps
interface cgocr_gate_if;
    logic srcClk;
    logic enable;
    logic clkOut;
    modport ctrl (output srcClk, output enable, input clkOut);
    modport gate (input srcClk, input enable, output clkOut);
endinterface

/* File: design/cgocr_clk_gate.sv */
// glitch-free stop/start gate for one output clock
`timescale 1ns/1ps
module cgocr_clk_gate (
    input wire logic clk,
    input wire logic rst_b,
    cgocr_gate_if.gate gif
);
    import cgocr_pkg::*;

    typedef struct packed {
        logic gateOn;
        logic clkOut;
    } cgocr_gate_state_t;

    cgocr_gate_state_t state_ff;
    cgocr_gate_state_t nxt_state;

    // ==========================================================
    // gate moves only while the source is low, so no pulse is cut
    always_comb begin
        nxt_state = state_ff;
        if (!gif.srcClk) begin
            nxt_state.gateOn = gif.enable;
        end
        nxt_state.clkOut = gif.srcClk & nxt_state.gateOn;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign gif.clkOut = state_ff.clkOut;

    // ==========================================================
    gate_edge_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(state_ff.gateOn) |-> !$past(gif.srcClk))
        else $error("gate moved while source high");

    stopped_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        !state_ff.gateOn |=> !state_ff.clkOut)
        else $error("stopped output not held low");

endmodule // cgocr_clk_gate

/* File: design/cgocr_regs.sv */
// serial target, configuration bank and output control
// Behaviour
// - byte 0 bit 2 enables the reference output; byte resets to 0x04.
// - byte 2 bit 7 enables clock A; byte resets to 0xc0.
// - byte 2 bit 6 enables clock B; bits 5..0 reserved.
// - byte 3 resets to revision code high nibble, maker code low nibble; read/write.
// - byte 4 is the block length, read/write, resets to 6.
// - byte 5 bit 7 picks default swing or the code in bits 6..4.
// - swing code maps 300 mV plus 100 mV per step, up to 1000 mV.
// - byte 5 resets to 0xd8, low nibble reserved and reset to 0x8.
// - byte 1 is reserved, read/write, resets to zero.
// - reference enable pin is active high; host drives it.
// - clock A enable pin is active high; host drives it.
// - clock B enable pin is active high; host drives it.
// - two select pins are latched and set rate and spread of both clocks.
// - an output runs only when its pin and its register bit are high.
// - select 00:100 flat, 01:100 spread, 10:125 flat, 11:200 flat.
// - serial target answers at address byte 0xd6.
// - a disabled output stops without a cut pulse and rests low.
`timescale 1ns/1ps
module cgocr_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclPin,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic refEnablePin,
    input wire logic pcieClockAEnablePin,
    input wire logic pcieClockBEnablePin,
    input wire logic rateSpreadSelectLow,
    input wire logic rateSpreadSelectHigh,
    input wire logic refSrcClk,
    input wire logic pcieSrcClk,
    output logic refClkOutput,
    output logic pcieClockAOutput,
    output logic pcieClockBOutput,
    output cgocr_pkg::cgocr_mv_t swingMillivolt,
    output cgocr_pkg::cgocr_byte_t rateMhz,
    output logic spreadOn,
    output logic rateValid
);
    import cgocr_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_CMD = 7'b000_0100,
        ST_CNT = 7'b000_1000,
        ST_WR = 7'b001_0000,
        ST_RD = 7'b010_0000,
        ST_SKIP = 7'b100_0000
    } cgocr_fsm_t;

    typedef struct packed {
        logic [SY_LANES-1:0] s1;
        logic [SY_LANES-1:0] s2;
        logic [SY_LANES-1:0] s3;
        logic [SY_LANES-1:0] lvl;
        cgocr_fsm_t st;
        cgocr_byte_t shReg;
        cgocr_byte_t txByte;
        logic [3:0] bitCnt;
        logic ackPhase;
        logic nack;
        logic sdaOe;
        logic isBlock;
        logic cntSent;
        logic [2:0] ptr;
        logic [REG_COUNT-1:0][7:0] regs;
        logic [1:0] fill;
        logic rateValid;
        logic [1:0] rateCode;
        cgocr_mv_t swingMv;
        cgocr_byte_t rateMhz;
        logic spreadOn;
    } cgocr_state_t;

    // bus lanes start at their pulled-up idle level, so release shows no false edge
    localparam logic [SY_LANES-1:0] LINE_IDLE = SY_LANES'((32'h0000_0001 << SY_SCL) | (32'h0000_0001 << SY_SDA));
    localparam cgocr_state_t RESET_VAL = '{st: ST_IDLE, regs: REG_RESET, s1: LINE_IDLE, s2: LINE_IDLE,
                                           s3: LINE_IDLE, lvl: LINE_IDLE, default: '0};

    cgocr_state_t state_ff;
    cgocr_state_t nxt_state;
    logic [SY_LANES-1:0] pinsRaw;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic byteEnd;
    logic wrStrobe;
    logic addrMatch;
    logic [2:0] swingCode;
    logic [NUM_OUTS-1:0] outEnable;
    logic [NUM_OUTS-1:0] outSrc;
    logic [NUM_OUTS-1:0] outClk;

    assign pinsRaw = {rateSpreadSelectHigh, rateSpreadSelectLow, pcieClockBEnablePin,
                      pcieClockAEnablePin, refEnablePin, sdaIn, sclPin};
    assign swingCode = state_ff.regs[IDX_SWING][SWING_CODE_HI:SWING_CODE_LO];
    assign addrMatch = (state_ff.shReg[7:1] == TARGET_ADDR[7:1]);

    // ==========================================================
    // main next-state logic
    always_comb begin
        nxt_state = state_ff;
        wrStrobe = 1'b0;
        // pins pass three stages; a level counts once stages two and three agree
        nxt_state.s1 = pinsRaw;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        nxt_state.lvl = (state_ff.s2 & state_ff.s3) | (state_ff.lvl & (state_ff.s2 ^ state_ff.s3));
        sclRise = nxt_state.lvl[SY_SCL] & ~state_ff.lvl[SY_SCL];
        sclFall = ~nxt_state.lvl[SY_SCL] & state_ff.lvl[SY_SCL];
        startCond = state_ff.lvl[SY_SCL] & nxt_state.lvl[SY_SCL] & state_ff.lvl[SY_SDA] & ~nxt_state.lvl[SY_SDA];
        stopCond = state_ff.lvl[SY_SCL] & nxt_state.lvl[SY_SCL] & ~state_ff.lvl[SY_SDA] & nxt_state.lvl[SY_SDA];
        byteEnd = sclFall & ~state_ff.ackPhase & (state_ff.bitCnt == 4'h8);

        if (startCond) begin
            nxt_state.st = ST_ADDR;
            nxt_state.bitCnt = 4'h0;
            nxt_state.ackPhase = 1'b0;
            nxt_state.sdaOe = 1'b0;
            nxt_state.cntSent = 1'b0;
        end else if (stopCond) begin
            nxt_state.st = ST_IDLE;
            nxt_state.ackPhase = 1'b0;
            nxt_state.sdaOe = 1'b0;
        end else if (sclRise) begin
            if (state_ff.ackPhase) begin
                nxt_state.nack = nxt_state.lvl[SY_SDA];
            end else if (state_ff.st != ST_IDLE && state_ff.st != ST_SKIP) begin
                nxt_state.shReg = {state_ff.shReg[6:0], nxt_state.lvl[SY_SDA]};
                nxt_state.bitCnt = state_ff.bitCnt + 4'h1;
            end
        end else if (sclFall) begin
            if (state_ff.ackPhase) begin
                nxt_state.ackPhase = 1'b0;
                nxt_state.sdaOe = 1'b0;
                nxt_state.bitCnt = 4'h0;
                if (state_ff.st == ST_RD) begin
                    if (state_ff.nack) begin
                        nxt_state.st = ST_SKIP;
                    end else begin
                        // block reads lead with the length byte
                        if (state_ff.isBlock && !state_ff.cntSent) begin
                            nxt_state.txByte = state_ff.regs[IDX_COUNT];
                            nxt_state.cntSent = 1'b1;
                        end else begin
                            nxt_state.txByte = (state_ff.ptr <= IDX_LAST) ? state_ff.regs[state_ff.ptr] : 8'h00;
                            nxt_state.ptr = state_ff.ptr + 3'h1;
                        end
                        nxt_state.sdaOe = ~nxt_state.txByte[7];
                    end
                end
            end else if (state_ff.bitCnt == 4'h8) begin
                unique case (state_ff.st)
                    ST_ADDR: begin
                        if (addrMatch) begin
                            nxt_state.ackPhase = 1'b1;
                            nxt_state.sdaOe = 1'b1;
                            nxt_state.st = state_ff.shReg[0] ? ST_RD : ST_CMD;
                        end else begin
                            nxt_state.st = ST_SKIP;
                        end
                    end
                    ST_CMD: begin
                        nxt_state.ackPhase = 1'b1;
                        nxt_state.sdaOe = 1'b1;
                        nxt_state.isBlock = ~state_ff.shReg[CMD_BYTE_MODE_BIT];
                        nxt_state.ptr = state_ff.shReg[2:0];
                        nxt_state.cntSent = 1'b0;
                        nxt_state.st = nxt_state.isBlock ? ST_CNT : ST_WR;
                    end
                    ST_CNT: begin
                        // the host's length byte only frames the burst
                        nxt_state.ackPhase = 1'b1;
                        nxt_state.sdaOe = 1'b1;
                        nxt_state.st = ST_WR;
                    end
                    ST_WR: begin
                        nxt_state.ackPhase = 1'b1;
                        nxt_state.sdaOe = 1'b1;
                        if (state_ff.ptr <= IDX_LAST) begin
                            wrStrobe = 1'b1;
                            nxt_state.regs[state_ff.ptr] = state_ff.shReg;
                        end
                        nxt_state.ptr = state_ff.ptr + 3'h1;
                    end
                    ST_RD: begin
                        nxt_state.ackPhase = 1'b1;
                        nxt_state.sdaOe = 1'b0;
                    end
                    ST_IDLE, ST_SKIP: begin
                    end
                endcase
            end else if (state_ff.st == ST_RD) begin
                nxt_state.sdaOe = ~state_ff.txByte[3'(4'h7 - state_ff.bitCnt)];
            end
        end

        // select pins latched once after reset; stages must fill first
        if (!state_ff.rateValid) begin
            if (state_ff.fill != SYNC_FILL) begin
                nxt_state.fill = state_ff.fill + 2'h1;
            end else begin
                nxt_state.rateValid = 1'b1;
                nxt_state.rateCode = {nxt_state.lvl[SY_SSH], nxt_state.lvl[SY_SSL]};
            end
        end
        unique case (state_ff.rateCode)
            SS_100_FLAT: begin
                nxt_state.rateMhz = RATE_100_MHZ;
                nxt_state.spreadOn = 1'b0;
            end
            SS_100_SPREAD: begin
                nxt_state.rateMhz = RATE_100_MHZ;
                nxt_state.spreadOn = 1'b1;
            end
            SS_125_FLAT: begin
                nxt_state.rateMhz = RATE_125_MHZ;
                nxt_state.spreadOn = 1'b0;
            end
            SS_200_FLAT: begin
                nxt_state.rateMhz = RATE_200_MHZ;
                nxt_state.spreadOn = 1'b0;
            end
        endcase

        // reserved low nibble has no part here
        if (state_ff.regs[IDX_SWING][SWING_SEL_BIT]) begin
            nxt_state.swingMv = SWING_BASE_MV + 10'(SWING_STEP_MV * {7'h00, swingCode});
        end else begin
            nxt_state.swingMv = SWING_DEFAULT_MV;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= RESET_VAL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // output enables: pin and bit must both be high
    assign outEnable[OUT_REF] = state_ff.regs[IDX_REF][REF_EN_BIT] & state_ff.lvl[SY_REF];
    assign outEnable[OUT_CLKA] = state_ff.regs[IDX_DIFF][CLKA_EN_BIT] & state_ff.lvl[SY_CLKA];
    assign outEnable[OUT_CLKB] = state_ff.regs[IDX_DIFF][CLKB_EN_BIT] & state_ff.lvl[SY_CLKB];
    assign outSrc = {pcieSrcClk, pcieSrcClk, refSrcClk};

    for (genvar i = 0; i < NUM_OUTS; i++) begin : g_out
        cgocr_gate_if gateBus();
        assign gateBus.srcClk = outSrc[i];
        assign gateBus.enable = outEnable[i];
        assign outClk[i] = gateBus.clkOut;
        cgocr_clk_gate u_gate (
            .clk(clk),
            .rst_b(rst_b),
            .gif(gateBus)
        );
    end

    assign refClkOutput = outClk[OUT_REF];
    assign pcieClockAOutput = outClk[OUT_CLKA];
    assign pcieClockBOutput = outClk[OUT_CLKB];
    assign sdaOut = 1'b0;
    assign sdaOe = state_ff.sdaOe;
    assign swingMillivolt = state_ff.swingMv;
    assign rateMhz = state_ff.rateMhz;
    assign spreadOn = state_ff.spreadOn;
    assign rateValid = state_ff.rateValid;

    // ==========================================================
    // checks
    sequence addr_byte_done;
        byteEnd && state_ff.st == ST_ADDR;
    endsequence

    reset_values_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> state_ff.regs == REG_RESET)
        else $error("bank not at reset values");

    addr_match_a: assert property (@(posedge clk) disable iff (!rst_b)
        addr_byte_done ##0 addrMatch |=> state_ff.sdaOe && state_ff.ackPhase)
        else $error("own address not acknowledged");

    addr_foreign_a: assert property (@(posedge clk) disable iff (!rst_b)
        addr_byte_done ##0 !addrMatch |=> !state_ff.sdaOe && state_ff.st == ST_SKIP)
        else $error("foreign address acknowledged");

    rsvd_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        wrStrobe && state_ff.ptr == IDX_RSVD |=> state_ff.regs[IDX_RSVD] == $past(state_ff.shReg))
        else $error("reserved byte not stored");

    swing_map_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff.regs[IDX_SWING][SWING_SEL_BIT] && swingCode == 3'h7 ##1 $stable(state_ff.regs[IDX_SWING])
        |=> swingMillivolt == 10'h3e8)
        else $error("swing code 7 not 1000 mV");

    rate_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        rateValid ##1 rateValid |-> $stable(state_ff.rateCode))
        else $error("latched select code moved");

    rate_spread_a: assert property (@(posedge clk) disable iff (!rst_b)
        rateValid && state_ff.rateCode == SS_100_SPREAD |=> spreadOn && rateMhz == RATE_100_MHZ)
        else $error("select 01 not 100 MHz with spread");

    pin_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        !pcieClockAEnablePin [*4] |=> !outEnable[OUT_CLKA])
        else $error("clock A enabled with pin low");

endmodule // cgocr_regs

/* File: tb/cgocr_i2c_host.sv */
// two-wire host model that configures the bank
`timescale 1ns/1ps
module cgocr_i2c_host (
    input wire logic clk,
    input wire logic sdaLine,
    output logic sclPin,
    output logic sdaLow
);
    // ==========================================
    // bus phases, all moves on falling clk edges
    initial begin
        sclPin = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // long low phase so the target's delayed ack release lands before our rise
    task automatic bitCycle(input logic drvLow, output logic seen);
        tick(4);
        sdaLow = drvLow;
        tick(2);
        sclPin = 1'b1;
        tick(1);
        seen = sdaLine;
        tick(1);
        sclPin = 1'b0;
    endtask
    // start and repeated start: data falls while clock high
    task automatic startCond();
        tick(4);
        sdaLow = 1'b0;
        tick(2);
        sclPin = 1'b1;
        tick(4);
        sdaLow = 1'b1;
        tick(4);
        sclPin = 1'b0;
    endtask
    // stop leaves the clock standing high
    task automatic stopCond();
        tick(4);
        sdaLow = 1'b1;
        tick(2);
        sclPin = 1'b1;
        tick(4);
        sdaLow = 1'b0;
        tick(4);
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) bitCycle(~b[i], seen);
        bitCycle(1'b0, seen);
        ack = ~seen;
    endtask
    task automatic recvByte(output logic [7:0] b, input logic nack);
        logic seen;
        for (int i = 7; i >= 0; i--) bitCycle(1'b0, b[i]);
        bitCycle(~nack, seen);
    endtask
endmodule // cgocr_i2c_host

/* File: tb/cgocr_regs_tb.sv */
// self-checking bench for the output configuration bank
`timescale 1ns/1ps
module cgocr_regs_tb;
    import cgocr_pkg::*;
    logic clk, rst_b, sclPin, sdaLow, dutOe, sdaOut, sdaLine, src, selLo, selHi, ack;
    logic refEnablePin, pcieClockAEnablePin, pcieClockBEnablePin;
    logic refClkOutput, pcieClockAOutput, pcieClockBOutput, spreadOn, rateValid;
    logic [2:0] outs, outsPrev, pins, bits;
    cgocr_mv_t swingMillivolt;
    cgocr_byte_t rateMhz;
    cgocr_byte_t regExp [6];
    int failures = 0;
    int check_count = 0;
    int runLen [3];
    int rises [3];
    // ==========================================
    // wiring: open-drain data line with pull-up
    assign sdaLine = ~(sdaLow | (dutOe & ~sdaOut));
    assign outs = {pcieClockBOutput, pcieClockAOutput, refClkOutput};
    cgocr_regs dut_u (.clk(clk), .rst_b(rst_b), .sclPin(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(dutOe), .refEnablePin(refEnablePin), .pcieClockAEnablePin(pcieClockAEnablePin),
        .pcieClockBEnablePin(pcieClockBEnablePin), .rateSpreadSelectLow(selLo),
        .rateSpreadSelectHigh(selHi), .refSrcClk(src), .pcieSrcClk(src), .refClkOutput(refClkOutput),
        .pcieClockAOutput(pcieClockAOutput), .pcieClockBOutput(pcieClockBOutput),
        .swingMillivolt(swingMillivolt), .rateMhz(rateMhz), .spreadOn(spreadOn), .rateValid(rateValid));
    cgocr_i2c_host host_u (.clk(clk), .sdaLine(sdaLine), .sclPin(sclPin), .sdaLow(sdaLow));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        src = 1'b0;
        forever begin
            repeat (2) @(negedge clk);
            src = ~src;
        end
    end
    // ==========================================
    // checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        check(16'h0, 16'h1, "run timeout");
        report_and_stop();
    end
    // every output pulse must be a whole source pulse; sampled away from the launching edge
    always @(negedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_b) runLen[i] = 0;
            else if (outs[i] === 1'b1) runLen[i]++;
            else if (runLen[i] != 0) begin
                check(16'(runLen[i]), 16'h2, "pulse width");
                runLen[i] = 0;
            end
            if (outs[i] === 1'b1 && outsPrev[i] !== 1'b1) rises[i]++;
        end
        outsPrev <= outs;
    end
    function automatic cgocr_byte_t rateOf(input logic [1:0] s);
        return (s[1] == 1'b0) ? 8'h64 : (s[0] ? 8'hc8 : 8'h7d);
    endfunction
    function automatic cgocr_mv_t swingOf(input cgocr_byte_t r);
        return r[7] ? 10'h12c + 10'h064 * 10'(r[6:4]) : 10'h2bc;
    endfunction
    // ==========================================
    // serial transfers
    task automatic regWrite(input logic [2:0] idx, input cgocr_byte_t d);
        logic a0, a1, a2;
        host_u.startCond();
        host_u.sendByte(8'hd6, a0);
        host_u.sendByte({5'h10, idx}, a1);
        host_u.sendByte(d, a2);
        host_u.stopCond();
        check({a0, a1, a2}, 3'h7, "write ack");
        if (idx <= IDX_LAST) regExp[idx] = d;
    endtask
    // blk=1 reads the count byte first, then n bytes from idx
    task automatic regRead(input logic [2:0] idx, input int n, input logic blk);
        logic a0, a1, a2;
        cgocr_byte_t d;
        host_u.startCond();
        host_u.sendByte(8'hd6, a0);
        host_u.sendByte({~blk, 4'h0, idx}, a1);
        host_u.startCond();
        host_u.sendByte(8'hd7, a2);
        check({a0, a1, a2}, 3'h7, "read ack");
        if (blk) begin
            host_u.recvByte(d, 1'b0);
            check(d, regExp[4], "count byte");
        end
        for (int k = 0; k < n; k++) begin
            host_u.recvByte(d, k == n - 1);
            check(d, (idx + k < REG_COUNT) ? regExp[idx + k] : 8'h00, "read data");
        end
        host_u.stopCond();
    endtask
    task automatic blockWrite(input logic [2:0] idx, input int n);
        int ok;
        cgocr_byte_t d;
        ok = 0;
        host_u.startCond();
        host_u.sendByte(8'hd6, ack);
        ok += ack;
        host_u.sendByte({5'h00, idx}, ack);
        ok += ack;
        host_u.sendByte(8'(n), ack);
        ok += ack;
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            host_u.sendByte(d, ack);
            ok += ack;
            regExp[idx + k] = d;
        end
        host_u.stopCond();
        check(16'(ok), 16'(n + 3), "block ack");
    endtask
    // select pins move after capture; the latched code must not
    task automatic resetDut(input logic [1:0] sel);
        rst_b = 1'b0;
        {selHi, selLo} = sel;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        regExp = '{8'h04, 8'h00, 8'hc0, RST_IDENT, 8'h06, 8'hd8};
        repeat (6) @(negedge clk);
        check({rateValid, spreadOn, rateMhz}, {1'b1, sel == 2'h1, rateOf(sel)}, "rate");
        check(swingMillivolt, swingOf(regExp[5]), "reset swing");
        {selHi, selLo} = ~sel;
        repeat (8) @(negedge clk);
        check({spreadOn, rateMhz}, {sel == 2'h1, rateOf(sel)}, "rate held");
        regRead(IDX_REF, 6, 1'b0);
    endtask
    // ==========================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        {selHi, selLo} = 2'h0;
        {pcieClockBEnablePin, pcieClockAEnablePin, refEnablePin} = 3'h7;
        void'($urandom(49));
        for (int s = 0; s < 4; s++) begin
            resetDut(2'(s));
            if (s == 0) begin
                for (int c = 0; c < 8; c++) begin
                    regWrite(IDX_SWING, {1'b1, 3'(c), 4'($urandom)});
                    check(swingMillivolt, swingOf(regExp[5]), "swing code");
                    regWrite(IDX_SWING, 8'($urandom) & 8'h7f);
                    check(swingMillivolt, swingOf(regExp[5]), "swing default");
                end
                regRead(IDX_SWING, 3, 1'b0);
            end
        end
        regWrite(IDX_COUNT, 8'h04);
        blockWrite(IDX_REF, 4);
        regRead(IDX_REF, 6, 1'b1);
        regWrite(IDX_COUNT, 8'($urandom));
        regRead(IDX_COUNT, 1, 1'b0);
        host_u.startCond();
        host_u.sendByte(8'hd6 ^ (8'h02 << ($urandom % 7)), ack);
        check(ack, 1'b0, "foreign address");
        host_u.sendByte({5'h10, IDX_RSVD}, ack);
        host_u.sendByte(8'hff, ack);
        host_u.stopCond();
        regRead(IDX_RSVD, 1, 1'b0);
        regWrite(3'h7, 8'($urandom));
        for (int t = 0; t < 12; t++) begin
            pins = (t == 0) ? 3'h7 : 3'($urandom);
            bits = (t < 2) ? 3'h7 - 3'(t * 7) : 3'($urandom);
            regWrite(IDX_REF, {5'($urandom), bits[0], 2'($urandom)});
            regWrite(IDX_DIFF, {bits[1], bits[2], 6'($urandom)});
            {pcieClockBEnablePin, pcieClockAEnablePin, refEnablePin} = pins;
            repeat (12) @(negedge clk);
            rises = '{0, 0, 0};
            repeat (24) @(negedge clk);
            check({rises[2] > 0, rises[1] > 0, rises[0] > 0}, pins & bits, "output run");
            check(outs & ~(pins & bits), 3'h0, "stopped low");
        end
        regRead(IDX_REF, 6, 1'b0);
        report_and_stop();
    end
endmodule // cgocr_regs_tb
